//--- hw/flash_seq_defs.svh
// Offsets, field positions, reset values and command codes of the flash sequencer.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH
// ****************
// Register offsets
// ****************
`define OFS_STATUS 8'h00
`define OFS_INDEX 8'h04
`define OFS_OBJECT 8'h08
`define OFS_ALLOW 8'h0C
`define OFS_PROT 8'h10
`define OFS_SECURE 8'h14
// ****************
// Status bit positions
// ****************
`define ST_COMMAND_COMPLETE_FLAG 7
`define ST_ACCESS_ERROR_FLAG 5
`define ST_PROTECTION_VIOLATION_FLAG 4
`define ST_MG1 1
`define ST_MG0 0
// ****************
// Reset values
// ****************
`define ALLOW_RST 4'hF
`define PROT_RST 17'h0_0000
// ****************
// Command codes and indices
// ****************
`define CMD_PGM 8'h06
`define CMD_ONCE 8'h07
`define CMD_ALL 8'h08
`define CMD_BLK 8'h09
`define CMD_SEC 8'h0A
`define IDX_PGM 3'h5
`define IDX_ALL 3'h0
`define IDX_ERS 3'h1
`define OBJ_WORDS 6
// ****************
// Array layout
// ****************
`define PF_BLK 2'h3
`define DF_BLK 2'h0
`define ERASED 64'hFFFF_FFFF_FFFF_FFFF
`endif

//--- hw/flash_seq_pkg.sv
// Types shared by the flash sequencer and its array macro port.
// Assumes the macro answers each request with a one-cycle done pulse.
package flash_seq_pkg;
    typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE, OP_BLANK} fl_op_t;
    typedef enum logic [1:0] {SC_PHRASE, SC_SECTOR, SC_BLOCK, SC_ALL} fl_scope_t;
    typedef struct packed {
        logic req;
        fl_op_t op;
        fl_scope_t scope;
        logic otp;
        logic [17:0] addr;
        logic [63:0] data;
    } fl_req_t;
    typedef struct packed {
        logic done;
        logic [63:0] rdata;
        logic ded;
    } fl_rsp_t;
endpackage : flash_seq_pkg

//--- hw/flash_seq.sv
// Command sequencer of the embedded flash controller with a Wishbone register slave.
// Assumes the array macro runs on clk_i and answers each request with fl_i.done.
`include "flash_seq_defs.svh"

// Functional notes
// - Program writes four words, reads them back, then sets the complete flag.
// - Program address must have its three low bits zero, else access error.
// - Program and one-time program need word index 101 at launch.
// - Program address must be a valid location, else access error.
// - Program into a protected region raises protection violation.
// - Verify errors set verify flag; uncorrectable ones set the other flag.
// - Commands other than whole erase need permission in the current mode.
// - One-time program checks erased phrase, programs, verifies, then completes.
// - One-time phrase index above seven raises access error.
// - Already programmed one-time phrase raises access error unless all ones.
// - During one-time program main array reads return invalid data.
// - Whole erase erases and verifies everything; security released on success.
// - Whole erase needs word index 000 at launch.
// - Whole erase with any protected region raises protection violation.
// - Block erase erases block chosen by address bits 17:16, verifies, completes.
// - Block and sector erase need index 001 and a valid block.
// - Block erase needs phrase alignment in program array, word in data.
// - Block erase of a block with protection raises protection violation.
// - Sector erase erases the containing program sector, verifies, completes.
// - Sector erase needs low bits 000; protected sector raises violation.
module flash_seq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output flash_seq_pkg::fl_req_t fl_o,
    input flash_seq_pkg::fl_rsp_t fl_i,
    output logic main_rd_invalid_o,
    output logic secure_o
);
    import flash_seq_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_BLANK, S_PROG, S_ERASE, S_VFY} state_t;

    // ****************
    // Registers
    // ****************
    state_t state_q;
    logic command_complete_flag_q;
    logic access_error_flag_q;
    logic protection_violation_flag_q;
    logic mg1_q;
    logic mg0_q;
    logic secure_q;
    logic [2:0] idx_q;
    logic [15:0] obj_q [0:`OBJ_WORDS-1];
    logic [3:0] allow_q;
    logic [16:0] prot_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ****************
    // Decode
    // ****************
    function automatic logic prot_hit(input logic [15:0] p, input logic [15:0] a);
        prot_hit = p[a[15:12]];
    endfunction : prot_hit

    logic req_ok;
    logic wr_en;
    logic launch;
    logic busy;
    logic [7:0] code;
    logic [1:0] blk;
    logic [15:0] ofs;
    logic is_pf;
    logic is_df;
    logic acc_chk;
    logic pv_chk;
    logic vfy_bad;
    logic [63:0] expect_w;

    assign req_ok = wb_cyc_i & wb_stb_i;
    assign busy = (state_q != S_IDLE);
    // Writes are dropped while a command runs, so a busy array is never disturbed.
    assign wr_en = req_ok & wb_we_i & ack_q & ~busy;
    assign launch = wr_en & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0] & wb_dat_i[`ST_COMMAND_COMPLETE_FLAG] & command_complete_flag_q
        & ~(access_error_flag_q & ~wb_dat_i[`ST_ACCESS_ERROR_FLAG]) & ~(protection_violation_flag_q & ~wb_dat_i[`ST_PROTECTION_VIOLATION_FLAG]);
    assign code = obj_q[0][15:8];
    assign blk = obj_q[0][1:0];
    assign ofs = obj_q[1];
    assign is_pf = (blk == `PF_BLK);
    assign is_df = (blk == `DF_BLK);
    assign expect_w = (code == `CMD_PGM || code == `CMD_ONCE)
        ? {obj_q[5], obj_q[4], obj_q[3], obj_q[2]} : `ERASED;
    assign vfy_bad = (fl_i.rdata != expect_w) | fl_i.ded;

    // ****************
    // Launch checks
    // ****************
    always_comb begin
        acc_chk = 1'b0;
        pv_chk = 1'b0;
        case (code)
            `CMD_PGM: begin
                acc_chk = (idx_q != `IDX_PGM)
                    | ~allow_q[0]
                    | ~is_pf
                    | (ofs[2:0] != 3'h0);
                pv_chk = prot_hit(prot_q[15:0], ofs);
            end
            `CMD_ONCE: begin
                acc_chk = (idx_q != `IDX_PGM)
                    | ~allow_q[1]
                    | (ofs[15:3] != 13'h0);
            end
            `CMD_ALL: begin
                acc_chk = (idx_q != `IDX_ALL);
                pv_chk = |prot_q;
            end
            `CMD_BLK: begin
                acc_chk = (idx_q != `IDX_ERS) | ~allow_q[2] | ~(is_pf | is_df)
                    | (is_pf & (ofs[2:0] != 3'h0)) | (is_df & ofs[0]);
                pv_chk = is_pf ? (|prot_q[15:0]) : prot_q[16];
            end
            `CMD_SEC: begin
                acc_chk = (idx_q != `IDX_ERS) | ~allow_q[3] | ~is_pf
                    | (ofs[2:0] != 3'h0);
                pv_chk = prot_hit(prot_q[15:0], ofs);
            end
            default: begin
                acc_chk = 1'b1;
            end
        endcase
    end

    // ****************
    // Sequencer
    // ****************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (launch) begin
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (acc_chk | pv_chk) begin
                        state_q <= S_IDLE;
                    end else if (code == `CMD_ONCE) begin
                        state_q <= S_BLANK;
                    end else if (code == `CMD_PGM) begin
                        state_q <= S_PROG;
                    end else begin
                        state_q <= S_ERASE;
                    end
                end
                S_BLANK: begin
                    if (fl_i.done) begin
                        state_q <= (fl_i.rdata == `ERASED) ? S_PROG : S_IDLE;
                    end
                end
                S_PROG: begin
                    if (fl_i.done) begin
                        state_q <= S_VFY;
                    end
                end
                S_ERASE: begin
                    if (fl_i.done) begin
                        state_q <= S_VFY;
                    end
                end
                S_VFY: begin
                    if (fl_i.done) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // ****************
    // Array request
    // ****************
    always_comb begin
        fl_o.req = (state_q == S_BLANK) | (state_q == S_PROG) | (state_q == S_ERASE) | (state_q == S_VFY);
        fl_o.otp = (code == `CMD_ONCE);
        fl_o.addr = fl_o.otp ? {15'h0, ofs[2:0]} : {blk, ofs};
        fl_o.data = {obj_q[5], obj_q[4], obj_q[3], obj_q[2]};
        case (code)
            `CMD_ALL: fl_o.scope = SC_ALL;
            `CMD_BLK: fl_o.scope = SC_BLOCK;
            `CMD_SEC: fl_o.scope = SC_SECTOR;
            default: fl_o.scope = SC_PHRASE;
        endcase
        case (state_q)
            S_PROG: fl_o.op = OP_PROG;
            S_ERASE: fl_o.op = OP_ERASE;
            S_VFY: fl_o.op = (fl_o.scope == SC_PHRASE) ? OP_READ : OP_BLANK;
            default: fl_o.op = OP_READ;
        endcase
    end

    assign main_rd_invalid_o = busy & (code == `CMD_ONCE);
    assign secure_o = secure_q;

    // ****************
    // Status flags
    // ****************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            command_complete_flag_q <= 1'b1;
        end else if (launch) begin
            command_complete_flag_q <= 1'b0;
        end else if (state_q == S_CHECK && (acc_chk | pv_chk)) begin
            command_complete_flag_q <= 1'b1;
        end else if (state_q == S_BLANK && fl_i.done && fl_i.rdata != `ERASED) begin
            command_complete_flag_q <= 1'b1;
        end else if (state_q == S_VFY && fl_i.done) begin
            command_complete_flag_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            access_error_flag_q <= 1'b0;
            protection_violation_flag_q <= 1'b0;
        end else begin
            if (wr_en && wb_adr_i == `OFS_STATUS && wb_sel_i[0]) begin
                access_error_flag_q <= access_error_flag_q & ~wb_dat_i[`ST_ACCESS_ERROR_FLAG];
                protection_violation_flag_q <= protection_violation_flag_q & ~wb_dat_i[`ST_PROTECTION_VIOLATION_FLAG];
            end
            if (state_q == S_CHECK && acc_chk) begin
                access_error_flag_q <= 1'b1;
            end
            if (state_q == S_CHECK && pv_chk) begin
                protection_violation_flag_q <= 1'b1;
            end
            if (state_q == S_BLANK && fl_i.done && fl_i.rdata != `ERASED) begin
                access_error_flag_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mg1_q <= 1'b0;
            mg0_q <= 1'b0;
        end else if (launch) begin
            mg1_q <= 1'b0;
            mg0_q <= 1'b0;
        end else if (state_q == S_VFY && fl_i.done) begin
            mg1_q <= vfy_bad;
            mg0_q <= fl_i.ded;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            secure_q <= 1'b1;
        end else if (state_q == S_VFY && fl_i.done && code == `CMD_ALL && !vfy_bad) begin
            secure_q <= 1'b0;
        end
    end

    // ****************
    // Register bus slave
    // ****************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_ok & ~ack_q;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (req_ok && !ack_q) begin
            case (wb_adr_i)
                `OFS_STATUS: dat_q <= {24'h0, command_complete_flag_q, 1'b0, access_error_flag_q, protection_violation_flag_q, 2'b00, mg1_q, mg0_q};
                `OFS_INDEX: dat_q <= {29'h0, idx_q};
                `OFS_OBJECT: dat_q <= (idx_q < 3'h6) ? {16'h0, obj_q[idx_q]} : 32'h0000_0000;
                `OFS_ALLOW: dat_q <= {28'h0, allow_q};
                `OFS_PROT: dat_q <= {15'h0, prot_q};
                `OFS_SECURE: dat_q <= {31'h0, secure_q};
                default: dat_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_q <= 3'h0;
            allow_q <= `ALLOW_RST;
            prot_q <= `PROT_RST;
        end else if (wr_en) begin
            if (wb_adr_i == `OFS_INDEX && wb_sel_i[0]) begin
                idx_q <= wb_dat_i[2:0];
            end
            if (wb_adr_i == `OFS_ALLOW && wb_sel_i[0]) begin
                allow_q <= wb_dat_i[3:0];
            end
            if (wb_adr_i == `OFS_PROT && wb_sel_i == 4'hF) begin
                prot_q <= wb_dat_i[16:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `OBJ_WORDS; i++) begin
                obj_q[i] <= 16'h0000;
            end
        end else if (wr_en && wb_adr_i == `OFS_OBJECT && idx_q < 3'h6) begin
            if (wb_sel_i[0]) begin
                obj_q[idx_q][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                obj_q[idx_q][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ****************
    // Assertions
    // ****************
    a_busy_command_complete_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q inside {S_PROG, S_ERASE, S_BLANK}) |-> !command_complete_flag_q)
        else $error("complete flag set during operation");
    a_reject_now: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_CHECK && (acc_chk || pv_chk)) |=> (command_complete_flag_q && state_q == S_IDLE && !fl_o.req))
        else $error("failed check did not complete at once");
    a_pgm_align: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_CHECK && code == `CMD_PGM && ofs[2:0] != 3'h0) |=> access_error_flag_q)
        else $error("misaligned program not flagged");
    a_pgm_index: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_CHECK && code == `CMD_ONCE && idx_q != 3'h5) |=> (access_error_flag_q && command_complete_flag_q))
        else $error("one-time index not checked");
    a_all_index: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_CHECK && code == `CMD_ALL && idx_q != 3'h0) |=> access_error_flag_q)
        else $error("whole erase index not checked");
    a_ers_prot: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_CHECK && code == `CMD_BLK && is_pf && prot_q[15:0] != 16'h0) |=> (protection_violation_flag_q && !busy))
        else $error("protected block erase not refused");
    a_otp_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (!command_complete_flag_q && code == `CMD_ONCE) |-> main_rd_invalid_o)
        else $error("main reads not blocked during one-time program");
    a_vfy_ded: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_VFY && fl_i.done && fl_i.ded) |=> (mg1_q && mg0_q && command_complete_flag_q))
        else $error("uncorrectable verify error not reported");
    a_sec_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_VFY && fl_i.done && vfy_bad) |=> (secure_q == $past(secure_q)))
        else $error("security released after failed verify");
    a_otp_used: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == S_BLANK && fl_i.done && fl_i.rdata != `ERASED) |=> (access_error_flag_q && state_q == S_IDLE))
        else $error("programmed one-time phrase accepted");
endmodule : flash_seq

//--- verification/test_flash_seq.sv
// Self-checking bench of the flash sequencer: Wishbone tasks, an array responder and command runs.
// Assumes the design acks in one cycle and that the bench itself plays the array macro.
`include "flash_seq_defs.svh"

module test_flash_seq;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_seq_pkg::*;

    // ****************
    // Signals
    // ****************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic wb_ack_o;
    logic main_rd_invalid_o;
    logic secure_o;
    fl_req_t fl_o;
    fl_rsp_t fl_i = '0;
    int error_cnt = 0;
    int tests_run = 0;
    int lat = 2;
    int wait_n = 0;
    int cnt = 0;
    logic [5:0] seq = 6'h00;
    logic [63:0] flip = 64'h0000_0000_0000_0000;
    logic [63:0] otp_val = 64'hFFFF_FFFF_FFFF_FFFF;
    logic [63:0] prog_q = 64'h0000_0000_0000_0000;
    logic ded_v = 1'b0;
    logic inval_seen = 1'b0;
    logic [16:0] prot_v = 17'h0_0000;
    logic [3:0] allow_v = 4'hF;
    fl_scope_t scope_q;
    logic [17:0] addr_q;

    always #25 clk_i = ~clk_i;

    flash_seq dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .fl_o(fl_o),
        .fl_i(fl_i),
        .main_rd_invalid_o(main_rd_invalid_o),
        .secure_o(secure_o)
    );

    // ****************
    // Array responder
    // ****************
    // Each step ends with a done pulse after lat idle cycles; flip corrupts verify data.
    always @(posedge clk_i) begin
        fl_i.done <= 1'b0;
        if (main_rd_invalid_o === 1'b1) begin
            inval_seen <= 1'b1;
        end
        if (fl_o.req !== 1'b1) begin
            wait_n <= lat;
        end else if (fl_i.done !== 1'b1) begin
            if (wait_n > 0) begin
                wait_n <= wait_n - 1;
            end else begin
                wait_n <= lat;
                fl_i.done <= 1'b1;
                fl_i.ded <= ded_v;
                cnt <= cnt + 1;
                seq <= {seq[3:0], fl_o.op};
                scope_q <= fl_o.scope;
                addr_q <= fl_o.addr;
                if (fl_o.op == OP_PROG) begin
                    prog_q <= fl_o.data;
                end
                fl_i.rdata <= (fl_o.op == OP_BLANK) ? (`ERASED ^ flip) : (cnt == 0) ? otp_val : (prog_q ^ flip);
            end
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 50) begin
            error_cnt++;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Loads the object, launches, polls the status and checks flags and array steps.
    task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] ix,
                       input logic [7:0] exp_st, input logic [7:0] exp_ops);
        int n;
        logic [15:0] obj [6];
        obj = '{w0, w1, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
        n = 0;
        wb(1'b1, `OFS_PROT, {15'h0000, prot_v});
        wb(1'b1, `OFS_ALLOW, {28'h000_0000, allow_v});
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, `OFS_INDEX, 32'(i));
            wb(1'b1, `OFS_OBJECT, {16'h0000, obj[i]});
        end
        wb(1'b1, `OFS_INDEX, {29'h0000_0000, ix});
        cnt = 0;
        seq = 6'h00;
        wb(1'b1, `OFS_STATUS, 32'h0000_00B0);
        rd = 32'h0000_0000;
        while (rd[7] !== 1'b1 && n < 200) begin
            n++;
            wb(1'b0, `OFS_STATUS, 32'h0000_0000);
        end
        chk("status", {56'h0, rd[7:0] & 8'hB3}, {56'h0, exp_st});
        chk("steps", {56'h0, cnt[1:0], seq}, {56'h0, exp_ops});
    endtask : run

    task automatic stop_test();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `OFS_ALLOW, 32'h0000_0000);
        chk("allow_reset", rd, 32'h0000_000F);
        wb(1'b0, `OFS_SECURE, 32'h0000_0000);
        chk("secure_reset", rd, 32'h0000_0001);
        wb(1'b0, 8'hFC, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        run(16'h0603, 16'h0100, `IDX_PGM, 8'h80, 8'h84);
        chk("pgm_addr", addr_q, 18'h3_0100);
        chk("pgm_data", prog_q, 64'h4444_3333_2222_1111);
        run(16'h0603, 16'h0104, `IDX_PGM, 8'hA0, 8'h00);
        run(16'h0603, 16'h0100, 3'h4, 8'hA0, 8'h00);
        run(16'h0601, 16'h0100, `IDX_PGM, 8'hA0, 8'h00);
        prot_v = 17'h0_0001;
        run(16'h0603, 16'h0100, `IDX_PGM, 8'h90, 8'h00);
        run(16'h0903, 16'h0000, `IDX_ERS, 8'h90, 8'h00);
        run(16'h0800, 16'h0000, `IDX_ALL, 8'h90, 8'h00);
        prot_v = 17'h0_0004;
        run(16'h0A03, 16'h2000, `IDX_ERS, 8'h90, 8'h00);
        prot_v = 17'h1_0000;
        run(16'h0900, 16'h0000, `IDX_ERS, 8'h90, 8'h00);
        prot_v = 17'h0_0000;
        flip = 64'h0000_0000_0000_0001;
        lat = 0;
        run(16'h0603, 16'h0100, `IDX_PGM, 8'h82, 8'h84);
        ded_v = 1'b1;
        run(16'h0603, 16'h0108, `IDX_PGM, 8'h83, 8'h84);
        ded_v = 1'b0;
        run(16'h0A03, 16'h2000, `IDX_ERS, 8'h82, 8'h8B);
        run(16'h0800, 16'h0000, `IDX_ALL, 8'h82, 8'h8B);
        chk("secure_kept", secure_o, 1'b1);
        chk("inval_idle", inval_seen, 1'b0);
        flip = 64'h0000_0000_0000_0000;
        lat = 2;
        allow_v = 4'h0;
        run(16'h0603, 16'h0100, `IDX_PGM, 8'hA0, 8'h00);
        run(16'h0700, 16'h0003, `IDX_PGM, 8'hA0, 8'h00);
        run(16'h0903, 16'h0000, `IDX_ERS, 8'hA0, 8'h00);
        run(16'h0A03, 16'h2000, `IDX_ERS, 8'hA0, 8'h00);
        allow_v = 4'hF;
        inval_seen = 1'b0;
        run(16'h0700, 16'h0003, `IDX_PGM, 8'h80, 8'hC4);
        chk("inval_busy", inval_seen, 1'b1);
        chk("inval_after", main_rd_invalid_o, 1'b0);
        chk("otp_addr", addr_q, 18'h0_0003);
        run(16'h0203, 16'h0000, 3'h0, 8'hA0, 8'h00);
        run(16'h0700, 16'h0008, `IDX_PGM, 8'hA0, 8'h00);
        run(16'h0700, 16'h0003, 3'h4, 8'hA0, 8'h00);
        otp_val = 64'h0000_1234_0000_0000;
        run(16'h0700, 16'h0003, `IDX_PGM, 8'hA0, 8'h40);
        otp_val = `ERASED;
        run(16'h0800, 16'h0000, 3'h1, 8'hA0, 8'h00);
        run(16'h0903, 16'h0000, `IDX_ERS, 8'h80, 8'h8B);
        chk("blk_scope", scope_q, SC_BLOCK);
        run(16'h0902, 16'h0000, `IDX_ERS, 8'hA0, 8'h00);
        run(16'h0903, 16'h0000, 3'h0, 8'hA0, 8'h00);
        run(16'h0903, 16'h0004, `IDX_ERS, 8'hA0, 8'h00);
        run(16'h0900, 16'h0001, `IDX_ERS, 8'hA0, 8'h00);
        run(16'h0900, 16'h0002, `IDX_ERS, 8'h80, 8'h8B);
        run(16'h0A03, 16'h2000, `IDX_ERS, 8'h80, 8'h8B);
        chk("sec_scope", scope_q, SC_SECTOR);
        run(16'h0A03, 16'h2003, `IDX_ERS, 8'hA0, 8'h00);
        run(16'h0A02, 16'h2000, `IDX_ERS, 8'hA0, 8'h00);
        allow_v = 4'h0;
        run(16'h0800, 16'h0000, `IDX_ALL, 8'h80, 8'h8B);
        chk("secure_freed", secure_o, 1'b0);
        stop_test();
    end
endmodule : test_flash_seq
